//--- bench/cfg_host.sv
// eeprom loader or smbus host model on the byte register port
`timescale 1ns/1ps
`default_nettype none
module cfg_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       write_o,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o
);
  // -------------------------------------------
  // byte transfers
  // -------------------------------------------
  initial begin
    write_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // one strobe per byte, so back-to-back writes leave an idle cycle
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    write_o <= 1'b1;
    @(posedge clk_i);
    write_o <= 1'b0;
  endtask
  // address held two edges so the registered answer has landed
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    repeat (2) @(posedge clk_i);
    #1 d = rdata_i;
  endtask
endmodule // cfg_host
`default_nettype wire

//--- bench/hub_string_regs_asserts.sv
// property checker for the hub string register bank
`timescale 1ns/1ps
`default_nettype none
module hub_string_regs_asserts (
  input wire logic         clk_i,
  input wire logic         reset_n_i,
  input wire logic         reg_write_i,
  input wire logic [7:0]   reg_addr_i,
  input wire logic [7:0]   reg_wdata_i,
  input wire logic [7:0]   reg_rdata_o,
  input wire logic         custom_strings_enable_i,
  input wire logic         custom_serial_enable_i,
  input wire logic [6:0]   product_string_length_i,
  input wire logic [7:0]   string_index_i,
  input wire logic [6:0]   string_byte_count_o,
  input wire logic         string_present_o,
  input wire logic [15:0]  language_code_o,
  input wire logic [127:0] container_id_o,
  input wire logic         container_id_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // -------------------------------------------
  // read-back and lookup relations
  // -------------------------------------------
  lang_low_a: assert property (reg_addr_i == 8'h20 |=> reg_rdata_o == language_code_o[7:0])
    else $error("language low byte mismatch");
  lang_high_a: assert property (reg_addr_i == 8'h21 |=> reg_rdata_o == language_code_o[15:8])
    else $error("language high byte mismatch");
  serial_field_a: assert property (reg_addr_i == 8'h22 |=> reg_rdata_o <= 8'h20)
    else $error("serial length out of range");
  maker_field_a: assert property (reg_addr_i == 8'h23 |=> reg_rdata_o <= 8'h40)
    else $error("maker length out of range");
  lang_count_a: assert property (string_index_i == 8'h00 |=> string_byte_count_o == 7'h02 && string_present_o)
    else $error("index zero count wrong");
  serial_count_a: assert property (string_index_i == 8'h01 && reg_addr_i == 8'h22 |=> string_byte_count_o == {1'b0, reg_rdata_o[5:0]})
    else $error("serial count wrong");
  product_count_a: assert property (string_index_i == 8'h02 |=> string_byte_count_o == $past(product_string_length_i))
    else $error("product count wrong");
  maker_count_a: assert property (string_index_i == 8'h03 && reg_addr_i == 8'h23 |=> string_byte_count_o == reg_rdata_o[6:0])
    else $error("maker count wrong");
  serial_lock_a: assert property ((reg_addr_i == 8'h22 && !custom_serial_enable_i) ##1 reg_addr_i == 8'h22 |=> $stable(reg_rdata_o))
    else $error("serial length changed while locked");
  id_format_a: assert property (container_id_valid_o |-> container_id_o[55:52] == 4'h4 && container_id_o[71:70] == 2'b10)
    else $error("identifier format bits wrong");
  cover property (reg_write_i && custom_serial_enable_i && reg_addr_i == 8'h22);
  cover property (string_index_i == 8'h03 ##1 string_present_o);
  cover property ($rose(container_id_valid_o));
endmodule // hub_string_regs_asserts
bind hub_string_regs hub_string_regs_asserts i_hub_string_regs_asserts (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_write_i(reg_write_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .custom_strings_enable_i(custom_strings_enable_i), .custom_serial_enable_i(custom_serial_enable_i),
  .product_string_length_i(product_string_length_i), .string_index_i(string_index_i),
  .string_byte_count_o(string_byte_count_o), .string_present_o(string_present_o),
  .language_code_o(language_code_o), .container_id_o(container_id_o),
  .container_id_valid_o(container_id_valid_o));
`default_nettype wire

//--- bench/hub_string_regs_test.sv
// self-checking bench for the hub string register bank
`timescale 1ns/1ps
`default_nettype none
module hub_string_regs_test;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic strings_en = 1'b0;
  logic serial_en = 1'b0;
  logic [6:0] prod_len = 7'h00;
  logic [7:0] idx = 8'h00;
  logic [7:0] d;
  wire write;
  wire [7:0] addr, wdata, rdata;
  wire [6:0] cnt;
  wire present, id_ok;
  wire [15:0] lang;
  wire [127:0] id;
  int n_errors = 0;
  int n_checks = 0;
  int i;
  always #2 clk_i = ~clk_i;
  cfg_host i_cfg_host (.clk_i(clk_i), .rdata_i(rdata), .write_o(write), .addr_o(addr),
    .wdata_o(wdata));
  hub_string_regs i_hub_string_regs (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_write_i(write),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .custom_strings_enable_i(strings_en), .custom_serial_enable_i(serial_en),
    .product_string_length_i(prod_len), .string_index_i(idx), .string_byte_count_o(cnt),
    .string_present_o(present), .language_code_o(lang), .container_id_o(id),
    .container_id_valid_o(id_ok));
  // -------------------------------------------
  // compare tasks and closing report
  // -------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_cfg_host.get(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic look(input logic [7:0] x, input logic [6:0] c, input logic p);
    @(posedge clk_i);
    idx <= x;
    repeat (2) @(posedge clk_i);
    #1 chk({8'h00, present, cnt}, {8'h00, p, c});
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 20 && id_ok !== 1'b1; i++) begin
      @(posedge clk_i);
    end
    if (i == 20) begin
      n_errors++;
      summarize();
    end
    // second pass proves writes were refused with both enables low
    for (i = 0; i < 2; i++) begin
      chk_reg(8'h20, 8'h09);
      chk_reg(8'h21, 8'h04);
      chk_reg(8'h22, 8'h18);
      chk_reg(8'h23, 8'h00);
      for (int j = 8'h20; j < 8'h24; j++) i_cfg_host.put(j[7:0], 8'h11);
    end
    chk(lang, 16'h0409);
    look(8'h00, 7'h02, 1'b1);
    chk_reg(8'h05, 8'h00);
    i_cfg_host.get(8'h16, d);
    chk({12'h000, d[7:4]}, 16'h0004);
    i_cfg_host.put(8'h16, ~d);
    chk_reg(8'h16, d);
    chk_reg(8'h1f, id[127:120]);
    i_cfg_host.get(8'h18, d);
    chk({14'h0000, d[7:6]}, 16'h0002);
    @(posedge clk_i);
    strings_en <= 1'b1;
    i_cfg_host.put(8'h20, 8'h07);
    i_cfg_host.put(8'h21, 8'h08);
    i_cfg_host.put(8'h23, 8'h41);
    chk_reg(8'h20, 8'h07);
    chk_reg(8'h23, 8'h40);
    chk(lang, 16'h0807);
    look(8'h03, 7'h40, 1'b1);
    i_cfg_host.put(8'h23, 8'h00);
    look(8'h03, 7'h00, 1'b0);
    // enable dropped again: the language byte must hold its written value
    @(posedge clk_i);
    strings_en <= 1'b0;
    i_cfg_host.put(8'h20, 8'h55);
    chk_reg(8'h20, 8'h07);
    @(posedge clk_i);
    serial_en <= 1'b1;
    i_cfg_host.put(8'h22, 8'h25);
    chk_reg(8'h22, 8'h20);
    i_cfg_host.put(8'h22, 8'h05);
    look(8'h01, 7'h05, 1'b1);
    @(posedge clk_i);
    prod_len <= 7'h11;
    look(8'h02, 7'h11, 1'b1);
    look(8'h04, 7'h00, 1'b0);
    summarize();
  end
endmodule // hub_string_regs_test
`default_nettype wire

//--- design/container_id_gen.v
// on-chip generator of the 16-byte container identifier
`timescale 1ns/1ps
`default_nettype none
module container_id_gen #(
  parameter [31:0] SEED = 32'h1234abcd  // arbitrary value
) (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        capture_i,
  output reg  [127:0] id_o,
  output reg         id_valid_o
);

  // ---------------------------------------------------------------
  // free-running lfsr, sampled on the first four cycles after reset for entropy of timing
  // ---------------------------------------------------------------
  reg [31:0] lfsr;
  reg [1:0]  step;
  wire [31:0] next_lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};

  // lfsr advances each cycle; four words fill the id
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lfsr       <= SEED;
      step       <= 2'h0;
      id_o       <= 128'h0;
      id_valid_o <= 1'b0;
    end else begin
      lfsr <= next_lfsr ^ (capture_i ? SEED : 32'h0);
      if (!id_valid_o) begin
        id_o <= {id_o[95:0], lfsr};
        step <= step + 2'h1;
        if (step == 2'h3) begin
          id_valid_o <= 1'b1;
          // force version 4 and variant 10 bits as the uuid format needs
          id_o[55:52] <= 4'h4;
          id_o[71:70] <= 2'h2;
        end
      end
    end
  end

endmodule // container_id_gen
`default_nettype wire

//--- design/hub_string_regs.v
// descriptor string configuration register bank of the hub
`timescale 1ns/1ps
`default_nettype none
`include "hub_string_regs.vh"
module hub_string_regs (
  input  wire        clk_i,
  input  wire        reset_n_i,
  // byte register port shared by eeprom loader and smbus host
  input  wire        reg_write_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  // customisation enables from the device configuration
  input  wire        custom_strings_enable_i,
  input  wire        custom_serial_enable_i,
  // product length held elsewhere, used for index 2 lookup
  input  wire [6:0]  product_string_length_i,
  // descriptor lookup
  input  wire [7:0]  string_index_i,
  output reg  [6:0]  string_byte_count_o,
  output reg         string_present_o,
  output reg  [15:0] language_code_o,
  output wire [127:0] container_id_o,
  output wire        container_id_valid_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg [7:0] language_code_low;
  reg [7:0] language_code_high;
  reg [`SERIAL_LEN_MSB:0] serial_string_length;
  reg [`MAKER_LEN_MSB:0]  maker_string_length;

  // identifier is made on chip; software cannot write it
  container_id_gen u_id (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .capture_i  (reg_write_i),
    .id_o       (container_id_o),
    .id_valid_o (container_id_valid_o)
  );

  wire wr_lang_low  = reg_write_i && reg_addr_i == `LANGUAGE_LOW_OFS;
  wire wr_lang_high = reg_write_i && reg_addr_i == `LANGUAGE_HIGH_OFS;
  wire wr_serial    = reg_write_i && reg_addr_i == `SERIAL_LEN_OFS;
  wire wr_maker     = reg_write_i && reg_addr_i == `MAKER_LEN_OFS;

  // ---------------------------------------------------------------
  // gated writes; oversized lengths are clamped to the limit
  // ---------------------------------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      language_code_low    <= `LANGUAGE_LOW_RST;
      language_code_high   <= `LANGUAGE_HIGH_RST;
      serial_string_length <= `SERIAL_LEN_RST;
      maker_string_length  <= `MAKER_LEN_RST;
    end else begin
      // writes without the enable fall through unchanged
      if (wr_lang_low && custom_strings_enable_i)
        language_code_low <= reg_wdata_i;
      if (wr_lang_high && custom_strings_enable_i)
        language_code_high <= reg_wdata_i;
      if (wr_serial && custom_serial_enable_i) begin
        // clamp rather than wrap so a bad load cannot overrun storage
        if (reg_wdata_i[7:0] > {2'h0, `SERIAL_LEN_MAX})
          serial_string_length <= `SERIAL_LEN_MAX;
        else
          serial_string_length <= reg_wdata_i[`SERIAL_LEN_MSB:0];
      end
      if (wr_maker && custom_strings_enable_i) begin
        if (reg_wdata_i[7:0] > {1'b0, `MAKER_LEN_MAX})
          maker_string_length <= `MAKER_LEN_MAX;
        else
          maker_string_length <= reg_wdata_i[`MAKER_LEN_MSB:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read data, registered
  // ---------------------------------------------------------------
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    if (reg_addr_i >= `CONTAINER_ID_FIRST && reg_addr_i <= `CONTAINER_ID_LAST)
      next_rdata = container_id_o[8*reg_addr_i[3:0] +: 8];
    else case (reg_addr_i)
      `LANGUAGE_LOW_OFS:  next_rdata = language_code_low;
      `LANGUAGE_HIGH_OFS: next_rdata = language_code_high;
      `SERIAL_LEN_OFS:    next_rdata = {2'h0, serial_string_length};
      `MAKER_LEN_OFS:     next_rdata = {1'b0, maker_string_length};
      default:            next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= next_rdata;
  end

  // ---------------------------------------------------------------
  // descriptor lookup: byte count per string index
  // ---------------------------------------------------------------
  reg [6:0] next_count;
  reg       next_present;
  always @* begin
    next_count   = 7'h00;
    next_present = 1'b0;
    case (string_index_i)
      `STR_INDEX_LANGUAGE: begin
        next_count   = 7'h02;  // one language code only
        next_present = 1'b1;
      end
      `STR_INDEX_SERIAL: begin
        next_count   = {1'b0, serial_string_length};
        next_present = serial_string_length != 6'h00;
      end
      `STR_INDEX_PRODUCT: begin
        next_count   = product_string_length_i;
        next_present = product_string_length_i != 7'h00;
      end
      `STR_INDEX_MAKER: begin
        next_count   = maker_string_length;
        next_present = maker_string_length != 7'h00;
      end
      default: begin
        next_count   = 7'h00;
        next_present = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      string_byte_count_o <= 7'h00;
      string_present_o    <= 1'b0;
      language_code_o     <= 16'h0000;
    end else begin
      string_byte_count_o <= next_count;
      string_present_o    <= next_present;
      language_code_o     <= {language_code_high, language_code_low};
    end
  end

endmodule // hub_string_regs
`default_nettype wire

//--- design/hub_string_regs.vh
// constant definitions for the hub descriptor string register bank
//
// Operation
// - read-only container id bytes at 0x10-0x1f
// - id bytes made on-chip, version-4 uuid format
// - language low byte at 0x20 resets 0x09
// - language high byte at 0x21 resets 0x04
// - exactly one language code reported, default 0x0409
// - custom strings enable opens language and maker writes
// - serial length bits 5:0 at 0x22, reset 0x18
// - serial string limited to 32 bytes
// - custom serial enable opens serial length writes
// - nonzero serial length returns bytes at index 1
// - reserved length bits read as zero
// - maker length bits 6:0 at 0x23, reset 0
// - maker string limited to 64 bytes
// - nonzero maker length returns bytes at index 3
// - nonzero product length returns bytes at index 2
`ifndef HUB_STRING_REGS_VH
`define HUB_STRING_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CONTAINER_ID_FIRST  8'h10
`define CONTAINER_ID_LAST   8'h1f
`define LANGUAGE_LOW_OFS    8'h20
`define LANGUAGE_HIGH_OFS   8'h21
`define SERIAL_LEN_OFS      8'h22
`define MAKER_LEN_OFS       8'h23

// ---------------------------------------------------------------
// reset values and field widths
// ---------------------------------------------------------------
`define LANGUAGE_LOW_RST    8'h09
`define LANGUAGE_HIGH_RST   8'h04
`define SERIAL_LEN_RST      6'h18
`define MAKER_LEN_RST       7'h00
`define SERIAL_LEN_MAX      6'h20
`define MAKER_LEN_MAX       7'h40
`define SERIAL_LEN_MSB      5
`define MAKER_LEN_MSB       6

// ---------------------------------------------------------------
// descriptor string indices
// ---------------------------------------------------------------
`define STR_INDEX_LANGUAGE  8'h00
`define STR_INDEX_SERIAL    8'h01
`define STR_INDEX_PRODUCT   8'h02
`define STR_INDEX_MAKER     8'h03

`endif
